/* src/vic_pkg.sv */
// shared constants of the combined vectored interrupt unit
// assumes one bus clock and a synchronous active-low reset
package vic_pkg;
   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int NUM_CHAN = 32;
   localparam int SUB_CHAN = 16;
   localparam int MAP_W    = 4;
   localparam int ID_W     = 5;
   localparam int ADDR_W   = 32;

   // ------------------------------------------------------------
   // vector table placement
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] VECT_BASE    = 32'h0000_0100;
   localparam logic [ADDR_W-1:0] VECT_DEFAULT = 32'h0000_0000;

   // ------------------------------------------------------------
   // registered state of the combiner
   // ------------------------------------------------------------
   typedef struct packed {
      logic              fast;
      logic              irq;
      logic              ack;
      logic              hit;
      logic [ID_W-1:0]   src;
      logic [ID_W-1:0]   chan;
      logic [ADDR_W-1:0] vect;
   } vic_state_t;
endpackage

/* src/vic_sub_unit.sv */
// one sixteen-channel vectored interrupt unit, purely combinational
// assumes requests and settings are on the bus clock
`timescale 1ns/1ps
module vic_sub_unit
   import vic_pkg::*;
(
   // sources and settings
   input  wire logic [SUB_CHAN-1:0]       src_req,
   input  wire logic [SUB_CHAN*MAP_W-1:0] chan_map,
   input  wire logic [SUB_CHAN-1:0]       chan_en,
   input  wire logic [SUB_CHAN-1:0]       chan_force,
   // result
   output logic      [SUB_CHAN-1:0]       chan_req,
   output logic                           any_req,
   output logic      [MAP_W-1:0]          win_chan,
   output logic      [MAP_W-1:0]          win_src
);
   // ------------------------------------------------------------
   // channel requests and fixed priority
   // ------------------------------------------------------------
   always_comb begin
      chan_req = '0;
      win_chan = '0;
      win_src  = '0;
      for (int c = 0; c < SUB_CHAN; c++) begin
         chan_req[c] = chan_en[c] & (src_req[chan_map[c*MAP_W +: MAP_W]] | chan_force[c]);
      end
      for (int c = SUB_CHAN - 1; c >= 0; c--) begin
         if (chan_req[c]) begin
            win_chan = MAP_W'(c);
            win_src  = chan_map[c*MAP_W +: MAP_W];
         end
      end
      any_req = |chan_req;
   end
endmodule // vic_sub_unit

/* src/vic_combiner.sv */
// combined vectored interrupt unit: two chained sub-units, fast path
// assumes all inputs come from logic on core_clk
`timescale 1ns/1ps

// Contract
// - 32 channels in, fast and normal out
// - primary and secondary sub-units merged
// - fast and normal requests raised side by side
// - fast path has no arbitration
// - any input selectable for fast path
// - normal request is OR of channels
// - channel 0 highest, 31 lowest
// - per-unit remap of source to channel
// - primary always outranks secondary
// - handler read returns source and vector
// - firmware can force any enabled channel
module vic_combiner
   import vic_pkg::*;
(
   // clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       rst_n,
   // interrupt sources
   input  wire logic [NUM_CHAN-1:0]        irq_src,
   // settings
   input  wire logic                       fast_en,
   input  wire logic [ID_W-1:0]            fast_sel,
   input  wire logic [NUM_CHAN*MAP_W-1:0]  chan_map,
   input  wire logic [NUM_CHAN-1:0]        chan_en,
   input  wire logic [NUM_CHAN-1:0]        chan_force,
   // processor requests
   output logic                            fast_irq_out,
   output logic                            irq_out,
   // handler read port
   input  wire logic                       rd_req,
   output logic                            rd_ack,
   output logic                            rd_hit,
   output logic      [ID_W-1:0]            rd_src,
   output logic      [ID_W-1:0]            rd_chan,
   output logic      [ADDR_W-1:0]          rd_vect
);
   // ------------------------------------------------------------
   // fast path selection
   // ------------------------------------------------------------
   logic [NUM_CHAN-1:0] fast_mask;
   logic [NUM_CHAN-1:0] norm_src;
   logic                fast_hit;

   always_comb begin
      fast_mask = '0;
      if (fast_en) begin
         fast_mask[fast_sel] = 1'h1;
      end
      norm_src = irq_src & ~fast_mask;
      fast_hit = |(irq_src & fast_mask);
   end

   // ------------------------------------------------------------
   // two chained sub-units
   // ------------------------------------------------------------
   logic [SUB_CHAN-1:0] p_req;
   logic [SUB_CHAN-1:0] s_req;
   logic                p_any;
   logic                s_any;
   logic [MAP_W-1:0]    p_chan;
   logic [MAP_W-1:0]    s_chan;
   logic [MAP_W-1:0]    p_src;
   logic [MAP_W-1:0]    s_src;

   vic_sub_unit primary_irq_unit (
      .src_req    (norm_src[SUB_CHAN-1:0]),
      .chan_map   (chan_map[SUB_CHAN*MAP_W-1:0]),
      .chan_en    (chan_en[SUB_CHAN-1:0]),
      .chan_force (chan_force[SUB_CHAN-1:0]),
      .chan_req   (p_req),
      .any_req    (p_any),
      .win_chan   (p_chan),
      .win_src    (p_src)
   );

   vic_sub_unit secondary_irq_unit (
      .src_req    (norm_src[NUM_CHAN-1:SUB_CHAN]),
      .chan_map   (chan_map[NUM_CHAN*MAP_W-1:SUB_CHAN*MAP_W]),
      .chan_en    (chan_en[NUM_CHAN-1:SUB_CHAN]),
      .chan_force (chan_force[NUM_CHAN-1:SUB_CHAN]),
      .chan_req   (s_req),
      .any_req    (s_any),
      .win_chan   (s_chan),
      .win_src    (s_src)
   );

   logic [NUM_CHAN-1:0] req_vec;
   assign req_vec = {s_req, p_req};

   // ------------------------------------------------------------
   // merged state
   // ------------------------------------------------------------
   vic_state_t state_q;
   vic_state_t state_d;

   always_comb begin
      state_d = state_q;
      state_d.fast = fast_hit;
      state_d.irq  = p_any | s_any;
      state_d.ack  = rd_req;
      if (rd_req) begin
         state_d.hit  = p_any | s_any;
         state_d.src  = '0;
         state_d.chan = '0;
         state_d.vect = VECT_DEFAULT;
         if (p_any) begin
            state_d.src  = {1'h0, p_src};
            state_d.chan = {1'h0, p_chan};
         end else if (s_any) begin
            state_d.src  = {1'h1, s_src};
            state_d.chan = {1'h1, s_chan};
         end
         if (p_any | s_any) begin
            state_d.vect = VECT_BASE + {25'h0, state_d.chan, 2'h0};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // fast has no arbitration stage
   assign fast_irq_out = state_q.fast;
   assign irq_out      = state_q.irq;
   assign rd_ack       = state_q.ack;
   assign rd_hit       = state_q.hit;
   assign rd_src       = state_q.src;
   assign rd_chan      = state_q.chan;
   assign rd_vect      = state_q.vect;

   // ------------------------------------------------------------
   // request checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   fast_set_a: assert property (fast_en && irq_src[fast_sel] |=> fast_irq_out)
      else $error("fast request missing");
   fast_clr_a: assert property (!fast_en |=> !fast_irq_out)
      else $error("fast request without selection");
   fast_drop_a: assert property (fast_en && !irq_src[fast_sel] |=> !fast_irq_out)
      else $error("fast request without source");
   both_out_a: assert property (fast_en && irq_src[fast_sel] && (|req_vec) |=> fast_irq_out && irq_out)
      else $error("fast request held back by normal");
   fast_only_a: assert property (fast_en && (irq_src == (32'h1 << fast_sel)) && !(|chan_force) |=> !irq_out)
      else $error("fast source reached normal path");
   irq_or_a: assert property (|req_vec |=> irq_out)
      else $error("normal request missing");
   irq_cause_a: assert property (irq_out |-> $past(req_vec) != 32'h0)
      else $error("normal request without channel");
   irq_drop_a: assert property (!(|req_vec) |=> !irq_out)
      else $error("normal request stuck");
   force_irq_a: assert property (chan_en[31] && chan_force[31] |=> irq_out)
      else $error("forced channel gave no request");
   last_chan_a: assert property (!fast_en && chan_en[31] && irq_src[SUB_CHAN + chan_map[127:124]]
                                 |=> irq_out)
      else $error("last channel not seen");
   fast_excl_a: assert property (fast_en && !chan_force[fast_sel] && (fast_sel < 5'h10)
                                 && chan_map[fast_sel*MAP_W +: MAP_W] == fast_sel[3:0]
                                 && chan_map[fast_sel*MAP_W +: MAP_W] != 4'hf
                                 |-> !p_req[fast_sel[3:0]] || fast_sel[4])
      else $error("fast source also on normal path");

   // ------------------------------------------------------------
   // read port checks
   // ------------------------------------------------------------
   read_ack_a: assert property (rd_req |=> rd_ack ##1 (rd_ack == $past(rd_req)))
      else $error("read answer timing wrong");
   no_read_a: assert property (!rd_req |=> !rd_ack)
      else $error("answer without read");
   read_hold_a: assert property (!rd_req |=> $stable(rd_src) && $stable(rd_chan) && $stable(rd_vect))
      else $error("read result changed without read");
   top_prio_a: assert property (rd_req && req_vec[0] |=> rd_hit && rd_chan == 5'h00)
      else $error("channel 0 not first");
   next_prio_a: assert property (rd_req && p_req[1] && !p_req[0] |=> rd_chan == 5'h01)
      else $error("channel 1 not second");
   prim_wins_a: assert property (rd_req && p_any |=> rd_hit && !rd_chan[4])
      else $error("secondary beat primary");
   prim_src_a: assert property (rd_req && p_any && s_any |=> !rd_src[4])
      else $error("secondary source beat primary");
   sec_merge_a: assert property (rd_req && !p_any && s_any |=> rd_hit && rd_chan[4] && rd_src[4])
      else $error("secondary unit not merged");
   remap_src_a: assert property (rd_req && p_req[0] |=> !rd_src[4] && rd_src[3:0] == $past(chan_map[3:0]))
      else $error("primary remap not applied");
   sec_remap_a: assert property (rd_req && !p_any && s_req[0]
                                 |=> rd_src[4] && rd_src[3:0] == $past(chan_map[67:64]))
      else $error("secondary remap not applied");
   force_chan_a: assert property (rd_req && chan_en[31] && chan_force[31] |=> rd_hit)
      else $error("forced channel ignored");
   force_win_a: assert property (rd_req && chan_en[31] && chan_force[31] && !(|req_vec[30:0])
                                 |=> rd_hit && rd_chan == 5'h1f)
      else $error("forced channel lost");
   vect_map_a: assert property (rd_ack && rd_hit |-> rd_vect == VECT_BASE + {25'h0, rd_chan, 2'h0})
      else $error("vector address mismatch");

   // ------------------------------------------------------------
   // cover points
   // ------------------------------------------------------------
   both_req_c: cover property (fast_irq_out && irq_out);
   sec_read_c: cover property (rd_ack && rd_hit && rd_chan[4]);
   empty_read_c: cover property (rd_ack && !rd_hit);
   fast_only_c: cover property (fast_irq_out && !irq_out);
   remap_read_c: cover property (rd_ack && rd_hit && rd_src != rd_chan);
endmodule // vic_combiner

/* bench/vic_core_model.sv */
// core model: takes requests, reads the handler port
// assumes the combiner on core_clk
`timescale 1ns/1ps
module vic_core_model (
   // clock and requests
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic fast_irq_out,
   input  wire logic irq_out,
   input  wire logic serve,
   // handler read
   input  wire logic rd_ack,
   output logic      rd_req
);
   logic busy_q;
   always_ff @(posedge core_clk) begin
      if (!rst_n || rd_ack) begin
         busy_q <= 1'b0;
         rd_req <= 1'b0;
      end else begin
         rd_req <= serve && irq_out && !fast_irq_out && !busy_q;
         busy_q <= busy_q || (serve && irq_out && !fast_irq_out);
      end
   end
endmodule // vic_core_model

/* bench/testbench.sv */
// bench for the combined interrupt unit
// assumes the core model issues reads
`timescale 1ns/1ps
module testbench
   import vic_pkg::*;
;
   logic                      core_clk, rst_n, fast_en, serve, rd_req;
   logic                      fast_irq_out, irq_out, rd_ack, rd_hit;
   logic [NUM_CHAN-1:0]       irq_src, chan_en, chan_force;
   logic [NUM_CHAN*MAP_W-1:0] chan_map;
   logic [ID_W-1:0]           fast_sel, rd_src, rd_chan;
   logic [ADDR_W-1:0]         rd_vect;
   int                        num_errors, n_tests, cyc;

   vic_combiner i_vic_combiner (.core_clk, .rst_n, .irq_src, .fast_en, .fast_sel, .chan_map,
      .chan_en, .chan_force, .fast_irq_out, .irq_out, .rd_req, .rd_ack, .rd_hit, .rd_src,
      .rd_chan, .rd_vect);
   vic_core_model i_vic_core_model (.core_clk, .rst_n, .fast_irq_out, .irq_out, .serve,
      .rd_ack, .rd_req);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk_bit(string nm, logic exp, logic got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic chk_word(string nm, logic [ADDR_W-1:0] exp, logic [ADDR_W-1:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s exp %h got %h", nm, exp, got);
      end
   endtask
   function automatic logic [NUM_CHAN*MAP_W-1:0] ident();
      for (int c = 0; c < NUM_CHAN; c++) ident[c*4 +: 4] = 4'(c);
   endfunction
   task automatic look();
      @(posedge core_clk);
      #1;
   endtask
   task automatic put(logic [NUM_CHAN-1:0] src);
      @(posedge core_clk);
      irq_src <= src;
      look();
   endtask
   task automatic rd(int c, int s);
      @(posedge core_clk);
      serve <= 1'b1;
      for (int i = 0; i < 8 && rd_ack !== 1'b1; i++) look();
      chk_bit("rd_ack", 1'b1, rd_ack);
      chk_bit("rd_hit", 1'b1, rd_hit);
      chk_word("rd_chan", ADDR_W'(c), ADDR_W'(rd_chan));
      chk_word("rd_src", ADDR_W'(s), ADDR_W'(rd_src));
      chk_word("rd_vect", VECT_BASE + ADDR_W'(c * 4), rd_vect);
      @(posedge core_clk);
      serve <= 1'b0;
   endtask
   task automatic conclude();
      $display("comparisons %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_chans();
      for (int c = 0; c < NUM_CHAN; c++) begin
         put(NUM_CHAN'(1) << c);
         chk_bit("irq_out", 1'b1, irq_out);
         rd(c, c);
         put('0);
         chk_bit("irq_out", 1'b0, irq_out);
      end
   endtask
   task automatic t_prio();
      logic [NUM_CHAN-1:0] pat [3] = '{32'h0010_0008, 32'h8001_0000, 32'h8000_c000};
      int                  win [3] = '{3, 16, 14};
      for (int i = 0; i < 3; i++) begin
         put(pat[i]);
         rd(win[i], win[i]);
      end
   endtask
   task automatic t_remap();
      @(posedge core_clk);
      chan_map[3:0] <= 4'h9;
      chan_map[39:36] <= 4'h0;
      chan_map[67:64] <= 4'h5;
      chan_map[87:84] <= 4'h0;
      put(32'h0022_0202);
      rd(0, 9);
      put(32'h0022_0000);
      rd(16, 21);
      chan_map <= ident();
   endtask
   task automatic t_force();
      put('0);
      @(posedge core_clk);
      chan_force <= 32'h8000_0000;
      look();
      chk_bit("irq_out", 1'b1, irq_out);
      rd(31, 31);
      chan_en <= 32'h7fff_ffef;
      put(32'h0000_0010);
      chk_bit("irq_out", 1'b0, irq_out);
      @(posedge core_clk);
      chan_en <= '1;
      chan_force <= '0;
   endtask
   task automatic t_fast();
      for (int s = 0; s < NUM_CHAN; s++) begin
         @(posedge core_clk);
         fast_en <= 1'b1;
         fast_sel <= ID_W'(s);
         irq_src <= NUM_CHAN'(1) << s;
         look();
         chk_bit("fast_irq_out", 1'b1, fast_irq_out);
         chk_bit("irq_out", 1'b0, irq_out);
      end
      @(posedge core_clk);
      fast_sel <= 5'h07;
      irq_src <= 32'h0000_0084;
      look();
      chk_bit("fast_irq_out", 1'b1, fast_irq_out);
      chk_bit("irq_out", 1'b1, irq_out);
      put(32'h0000_0004);
      chk_bit("fast_irq_out", 1'b0, fast_irq_out);
      rd(2, 2);
   endtask

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      rst_n = 1'b0;
      fast_en = 1'b0;
      serve = 1'b0;
      fast_sel = '0;
      irq_src = '0;
      chan_en = '1;
      chan_force = '0;
      chan_map = ident();
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      look();
      chk_bit("irq_out", 1'b0, irq_out);
      t_chans();
      t_prio();
      t_remap();
      t_force();
      t_fast();
      conclude();
   end
endmodule // testbench
